// ==== design/gtpwm_timer.sv ====
/*
 * Timer core: prescaler, 16-bit base counter, byte access with coherent
 * reads, preload/shadow period and compare, PWM output, events, input filter.
 * Assumes software drives the byte strobes synchronously to sys_clk.
 */
`timescale 1ns/1ps

module gtpwm_timer (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [2:0] prescale_select,
	input wire logic timer_run_enable,
	input wire logic [1:0] output_level_mode,
	input wire logic output_polarity,
	input wire logic input_filter_enable,
	input wire logic input_pin_select,
	input wire logic input_source_subselect,
	input wire logic pin_a,
	input wire logic pin_b,
	input wire logic wr_strobe,
	input wire logic [2:0] wr_sel,
	input wire logic [7:0] wr_data,
	input wire logic rd_hi_strobe,
	input wire logic rd_lo_strobe,
	input wire logic compare_flag_clear,
	input wire logic overflow_flag_clear,
	output logic [7:0] rd_data,
	output logic pwm_out,
	output logic compare_flag,
	output logic overflow_flag,
	output logic timer_irq,
	output logic rise_seen,
	output logic fall_seen,
	output logic timer_input_signal
);
	logic [7:0] psc_cnt_q;
	logic [15:0] base_count_q;
	logic [15:0] period_pre_q;
	logic [15:0] compare_pre_q;
	logic [15:0] period_value_q;
	logic [15:0] compare_value_q;
	logic [7:0] lo_latch_q;
	logic [7:0] rd_data_q;
	logic pwm_q;
	logic cmp_flag_q;
	logic ovf_flag_q;
	logic irq_q;
	gtpwm_pkg::gtpwm_load_t load_q;
	logic [2:0] filt_cnt_q;
	logic filt_q;
	logic filt_prev_q;
	logic rise_q;
	logic fall_q;

	// Divider terminal value: ratio minus one from the select code
	function automatic logic [7:0] psc_last(input logic [2:0] code);
		psc_last = 8'((9'h001 << code) - 9'h001);
	endfunction : psc_last

	// Prescaler tick and base counter events
	wire [7:0] psc_top = psc_last(prescale_select);
	wire tick = timer_run_enable && (psc_cnt_q == psc_top);
	wire out_mode = (output_level_mode == gtpwm_pkg::MODE_OUTPUT);
	wire hit_cmp = tick && (base_count_q == compare_value_q);
	wire hit_ovf = tick && (base_count_q == period_value_q);
	wire wr_cnt_hi = wr_strobe && (wr_sel == gtpwm_pkg::SEL_COUNT_HI);
	wire wr_cnt_lo = wr_strobe && (wr_sel == gtpwm_pkg::SEL_COUNT_LO);
	wire wr_per_hi = wr_strobe && (wr_sel == gtpwm_pkg::SEL_PERIOD_HI);
	wire wr_per_lo = wr_strobe && (wr_sel == gtpwm_pkg::SEL_PERIOD_LO);
	wire wr_cmp_hi = wr_strobe && (wr_sel == gtpwm_pkg::SEL_COMPARE_HI);
	wire wr_cmp_lo = wr_strobe && (wr_sel == gtpwm_pkg::SEL_COMPARE_LO);
	wire any_hi = wr_per_hi || wr_cmp_hi;
	wire any_lo = wr_per_lo || wr_cmp_lo;
	// A half-written preload must never become active
	wire half_open = (load_q == gtpwm_pkg::GTPWM_HALF) || any_hi;
	wire xfer = !half_open && (hit_ovf || !timer_run_enable);

	// Prescaler: free counting only while the timer runs
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			psc_cnt_q <= gtpwm_pkg::PSC_CNT_RESET;
		end else if (!timer_run_enable || tick) begin
			psc_cnt_q <= gtpwm_pkg::PSC_CNT_RESET;
		end else begin
			psc_cnt_q <= psc_cnt_q + 8'h01;
		end
	end

	// Base counter; a direct write wins over counting
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			base_count_q <= gtpwm_pkg::COUNT_RESET;
		end else if (wr_cnt_hi) begin
			base_count_q <= {wr_data, base_count_q[7:0]};
		end else if (wr_cnt_lo) begin
			base_count_q <= {base_count_q[15:8], wr_data};
		end else if (hit_ovf) begin
			base_count_q <= gtpwm_pkg::COUNT_RESET;
		end else if (tick) begin
			base_count_q <= base_count_q + 16'h0001;
		end
	end

	// Preload registers take the software bytes
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			period_pre_q <= gtpwm_pkg::PERIOD_RESET;
			compare_pre_q <= gtpwm_pkg::COMPARE_RESET;
		end else begin
			if (wr_per_hi) period_pre_q[15:8] <= wr_data;
			if (wr_per_lo) period_pre_q[7:0] <= wr_data;
			if (wr_cmp_hi) compare_pre_q[15:8] <= wr_data;
			if (wr_cmp_lo) compare_pre_q[7:0] <= wr_data;
		end
	end

	// Byte pairing tracker: open after a high byte, closed by a low byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			load_q <= gtpwm_pkg::GTPWM_IDLE;
		end else begin
			case (load_q)
				gtpwm_pkg::GTPWM_IDLE: if (any_hi) load_q <= gtpwm_pkg::GTPWM_HALF;
				gtpwm_pkg::GTPWM_HALF: if (any_lo) load_q <= gtpwm_pkg::GTPWM_IDLE;
				default: load_q <= gtpwm_pkg::GTPWM_IDLE;
			endcase
		end
	end

	// Shadow registers; the low byte lands in preload one edge before it can move
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			period_value_q <= gtpwm_pkg::PERIOD_RESET;
			compare_value_q <= gtpwm_pkg::COMPARE_RESET;
		end else if (xfer) begin
			period_value_q <= period_pre_q;
			compare_value_q <= compare_pre_q;
		end
	end

	// Output level: low while count <= compare for polarity 0
	wire at_or_below = (base_count_q <= compare_value_q);
	wire eq_hold = (compare_value_q == period_value_q);
	wire level_raw = eq_hold ? 1'b0 : !at_or_below;
	wire pwm_d = out_mode ? (level_raw ^ output_polarity) : output_polarity;

	// Flags: a new event wins over a clear in the same cycle
	wire cmp_set = out_mode && hit_cmp;
	wire ovf_set = out_mode && hit_ovf;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pwm_q <= 1'b0;
			cmp_flag_q <= 1'b0;
			ovf_flag_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			pwm_q <= pwm_d;
			cmp_flag_q <= cmp_set || (cmp_flag_q && !compare_flag_clear);
			ovf_flag_q <= ovf_set || (ovf_flag_q && !overflow_flag_clear);
			irq_q <= cmp_set || ovf_set || (cmp_flag_q && !compare_flag_clear)
				|| (ovf_flag_q && !overflow_flag_clear);
		end
	end

	// Coherent read: high byte read snapshots the low byte
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lo_latch_q <= 8'h00;
			rd_data_q <= 8'h00;
		end else if (rd_hi_strobe) begin
			lo_latch_q <= base_count_q[7:0];
			rd_data_q <= base_count_q[15:8];
		end else if (rd_lo_strobe) begin
			rd_data_q <= lo_latch_q;
		end
	end

	// Input routing: the subselect keeps the second pin reachable only when set
	wire raw_in = (input_pin_select && input_source_subselect) ? pin_b : pin_a;
	// Filter: a change must stand five samples, so pulses of 4 cycles die; costs lag
	wire differs = (raw_in != filt_q);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_cnt_q <= 3'h0;
			filt_q <= 1'b0;
		end else if (!input_filter_enable) begin
			filt_cnt_q <= 3'h0;
			filt_q <= raw_in;
		end else if (!differs) begin
			filt_cnt_q <= 3'h0;
		end else if (filt_cnt_q == gtpwm_pkg::FILTER_LAST) begin
			filt_cnt_q <= 3'h0;
			filt_q <= raw_in;
		end else begin
			filt_cnt_q <= filt_cnt_q + 3'h1;
		end
	end

	// Edge detection on the filtered level
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			filt_prev_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			filt_prev_q <= filt_q;
			rise_q <= filt_q && !filt_prev_q;
			fall_q <= !filt_q && filt_prev_q;
		end
	end

	assign rd_data = rd_data_q;
	assign pwm_out = pwm_q;
	assign compare_flag = cmp_flag_q;
	assign overflow_flag = ovf_flag_q;
	assign timer_irq = irq_q;
	assign rise_seen = rise_q;
	assign fall_seen = fall_q;
	assign timer_input_signal = filt_prev_q;

	// Overflow clears the counter on the next edge
	overflow_clears_count_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		hit_ovf && !wr_cnt_hi && !wr_cnt_lo |=> base_count_q == 16'h0000)
		else $error("counter not cleared after overflow");
	// Counter stands still while stopped
	stopped_count_holds_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!timer_run_enable && !wr_cnt_hi && !wr_cnt_lo |=> $stable(base_count_q))
		else $error("counter moved while stopped");
	// Count advances by one on each tick short of overflow
	count_steps_one_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		tick && !hit_ovf && !wr_cnt_hi && !wr_cnt_lo
		|=> base_count_q == $past(base_count_q) + 16'h0001)
		else $error("counter did not step by one");
	// Enabled cycles counted apart from the divider, so its ratio is checked independently
	wire [7:0] gap_mask = (8'h01 << prescale_select) - 8'h01;
	logic [7:0] gap_q;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			gap_q <= 8'h00;
		end else if (!timer_run_enable) begin
			gap_q <= 8'h00;
		end else begin
			gap_q <= gap_q + 8'h01;
		end
	end
	// Ticks fall on every 2^code-th enabled cycle; a code change while running breaks this
	prescale_ratio_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		timer_run_enable |-> tick == ((gap_q & gap_mask) == gap_mask))
		else $error("prescaler tick out of step");
	// No shadow load while a pair is half written
	half_write_block_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		load_q == gtpwm_pkg::GTPWM_HALF && !any_hi |=> $stable(period_value_q))
		else $error("shadow loaded from half-written value");
	// Stopped timer copies preload to shadow
	stop_loads_shadow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!timer_run_enable && load_q == gtpwm_pkg::GTPWM_IDLE && !any_hi
		|=> compare_value_q == $past(compare_pre_q))
		else $error("shadow not loaded while stopped");
	// Compare hit raises the flag
	compare_flag_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		cmp_set |=> compare_flag && timer_irq)
		else $error("compare flag not raised");
	// Overflow raises the flag, kept against a same-cycle clear
	overflow_flag_set_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		ovf_set |=> overflow_flag && timer_irq)
		else $error("overflow flag not raised");
	// Flag holds until cleared
	flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		compare_flag && !compare_flag_clear |=> compare_flag)
		else $error("compare flag dropped without clear");
	// Interrupt request mirrors the sticky flags
	irq_matches_flags_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		timer_irq == (compare_flag || overflow_flag))
		else $error("interrupt request differs from flags");
	// Equal compare and period forces the polarity level
	equal_level_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		out_mode && eq_hold |=> pwm_out == $past(output_polarity))
		else $error("equal compare did not hold level");
	// Outside output mode the pin rests at the polarity level and no flag rises
	idle_mode_quiet_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!out_mode && !compare_flag && !overflow_flag
		|=> pwm_out == $past(output_polarity) && !compare_flag && !overflow_flag)
		else $error("output mode work outside output mode");
	// High byte read returns the upper count byte
	high_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rd_hi_strobe |=> rd_data == $past(base_count_q[15:8]))
		else $error("high byte read wrong");
	// Low byte read returns the snapshot from the high byte read
	coherent_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		rd_hi_strobe ##1 (rd_lo_strobe && !rd_hi_strobe) |=> rd_data == $past(base_count_q[7:0], 2))
		else $error("low byte read not coherent");
	// A fresh change never passes the filter at its first sample
	filter_reject_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!differs ##1 (differs && input_filter_enable) |=> !$changed(filt_q))
		else $error("filter passed a one-cycle change");
	// A filtered rising level gives one edge pulse
	rise_pulse_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
		$rose(filt_q) |=> rise_seen && !fall_seen)
		else $error("rising edge not reported");
endmodule : gtpwm_timer

// ==== common/gtpwm_pkg.sv ====
/*
 * Constants for the general-purpose 16-bit timer with PWM output.
 * Assumes a single system clock and a byte-wide software access port.
 */
package gtpwm_pkg;
	localparam int CNT_W = 16;
	localparam int PSC_W = 3;
	localparam int PSC_DIV_W = 8;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] PERIOD_RESET = 16'h0000;
	localparam logic [15:0] COMPARE_RESET = 16'h0000;
	localparam logic [7:0] PSC_CNT_RESET = 8'h00;
	localparam logic [1:0] MODE_OUTPUT = 2'h1;
	localparam int FILTER_CYCLES = 4;
	// Last count before the filter follows: a change must stand for five samples
	localparam logic [2:0] FILTER_LAST = 3'h4;
	// Byte targets of the software write port
	localparam logic [2:0] SEL_COUNT_HI = 3'h0;
	localparam logic [2:0] SEL_COUNT_LO = 3'h1;
	localparam logic [2:0] SEL_PERIOD_HI = 3'h2;
	localparam logic [2:0] SEL_PERIOD_LO = 3'h3;
	localparam logic [2:0] SEL_COMPARE_HI = 3'h4;
	localparam logic [2:0] SEL_COMPARE_LO = 3'h5;
	// Byte load state: Gray coded
	typedef enum logic [1:0] {
		GTPWM_IDLE = 2'b00,
		GTPWM_HALF = 2'b01
	} gtpwm_load_t;
endpackage : gtpwm_pkg

// ==== verification/gtpwm_pulse_src.sv ====
/* Model of the external pulse source on the timer input pins.
   Assumes the bench asks for one pulse at a time, synchronous to sys_clk. */
`timescale 1ns/1ps
module gtpwm_pulse_src (
	input wire logic sys_clk,
	input wire logic go,
	input wire logic [3:0] width,
	output logic pin
);
	int left = 0;
	// One raw high pulse of the asked width, then back to the idle low level
	always @(posedge sys_clk) begin
		if (go) begin
			left <= width;
		end else if (left > 0) begin
			left <= left - 1;
		end
	end
	assign pin = (left > 0);
endmodule : gtpwm_pulse_src

// ==== verification/general_timer_pwm_output_test.sv ====
/* Self-checking bench for the timer core with a pulse source on its pins.
   Assumes the core follows the byte port and flag timing of its hand-over. */
`timescale 1ns/1ps
module general_timer_pwm_output_test;
	logic sys_clk = 1'b0, reset_n = 1'b0, timer_run_enable = 1'b0, output_polarity = 1'b0;
	logic [2:0] prescale_select = 3'h0, wr_sel = 3'h0;
	logic [1:0] output_level_mode = 2'h1;
	logic input_filter_enable = 1'b0, input_pin_select = 1'b0, input_source_subselect = 1'b0;
	logic wr_strobe = 1'b0, rd_hi_strobe = 1'b0, rd_lo_strobe = 1'b0, go = 1'b0;
	logic compare_flag_clear = 1'b0, overflow_flag_clear = 1'b0;
	logic [7:0] wr_data = 8'h00, rd_data, dh, dl;
	logic [3:0] width = 4'h0;
	logic pwm_out, compare_flag, overflow_flag, timer_irq, rise_seen, fall_seen;
	logic timer_input_signal, src_pin, pin_a, pin_b;
	logic [31:0] seed = 32'h00012fad;
	int err_total = 0, cmp_count = 0, cyc = 0, rises = 0, falls = 0, ins = 0, p, c, k, pol;
	// Unselected pin stays quiet so a wrong route loses the pulse
	assign pin_a = (input_pin_select & input_source_subselect) ? 1'b0 : src_pin;
	assign pin_b = input_pin_select & input_source_subselect & src_pin;
	always #12.5 sys_clk = ~sys_clk;
	gtpwm_timer i_dut (.sys_clk, .reset_n, .prescale_select, .timer_run_enable,
		.output_level_mode, .output_polarity, .input_filter_enable, .input_pin_select,
		.input_source_subselect, .pin_a, .pin_b, .wr_strobe, .wr_sel, .wr_data,
		.rd_hi_strobe, .rd_lo_strobe, .compare_flag_clear, .overflow_flag_clear,
		.rd_data, .pwm_out, .compare_flag, .overflow_flag, .timer_irq, .rise_seen,
		.fall_seen, .timer_input_signal);
	gtpwm_pulse_src i_src (.sys_clk, .go, .width, .pin(src_pin));
	// Edge pulses counted on the falling edge, away from the design's updates
	always @(negedge sys_clk) begin
		if (rise_seen === 1'b1) rises++;
		if (fall_seen === 1'b1) falls++;
		if (timer_input_signal === 1'b1) ins++;
	end
	// Hang guard, far above the few thousand cycles the run needs
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			print_verdict();
		end
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic print_verdict;
		if (err_total == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			err_total++;
		end
	endtask : chk
	task automatic wr(input logic [2:0] sel, input logic [7:0] dat);
		@(posedge sys_clk);
		wr_strobe <= 1'b1;
		wr_sel <= sel;
		wr_data <= dat;
		@(posedge sys_clk);
		wr_strobe <= 1'b0;
	endtask : wr
	task automatic wr16(input logic [2:0] sel, input logic [15:0] val);
		wr(sel, val[15:8]);
		wr(sel + 3'h1, val[7:0]);
	endtask : wr16
	task automatic rd(input logic hi, output logic [7:0] dat);
		@(posedge sys_clk);
		rd_hi_strobe <= hi;
		rd_lo_strobe <= ~hi;
		@(posedge sys_clk);
		rd_hi_strobe <= 1'b0;
		rd_lo_strobe <= 1'b0;
		#1 dat = rd_data;
	endtask : rd
	// Runs n enabled cycles; PWM high samples counted after the first skip
	task automatic run(input int n, input int skip, output int highs);
		highs = 0;
		@(posedge sys_clk);
		timer_run_enable <= 1'b1;
		for (int i = 0; i < n; i++) begin
			#1 if (i >= skip && pwm_out === 1'b1) highs++;
			@(posedge sys_clk);
		end
		timer_run_enable <= 1'b0;
		#1;
	endtask : run
	task automatic clr;
		@(posedge sys_clk);
		compare_flag_clear <= 1'b1;
		overflow_flag_clear <= 1'b1;
		@(posedge sys_clk);
		compare_flag_clear <= 1'b0;
		overflow_flag_clear <= 1'b0;
		#1;
	endtask : clr
	task automatic edge_case(input logic fe, ps, ss, input logic [3:0] w, input int exp);
		@(posedge sys_clk);
		input_filter_enable <= fe;
		input_pin_select <= ps;
		input_source_subselect <= ss;
		width <= w;
		repeat (12) @(posedge sys_clk);
		rises = 0;
		falls = 0;
		ins = 0;
		go <= 1'b1;
		@(posedge sys_clk);
		go <= 1'b0;
		repeat (30) @(posedge sys_clk);
		chk("rise count", 16'(exp), 16'(rises));
		chk("fall count", 16'(exp), 16'(falls));
		chk("filtered high cycles", 16'(exp * w), 16'(ins));
	endtask : edge_case
	initial begin
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(1'b1, dh);
		rd(1'b0, dl);
		chk("count after reset", 16'h0000, {dh, dl});
		chk("flags after reset", 16'h0000, {compare_flag, overflow_flag, timer_irq});
		// Every divide code: 512 enabled cycles give 512 >> code ticks
		wr16(gtpwm_pkg::SEL_PERIOD_HI, 16'hffff);
		for (int s = 0; s < 8; s++) begin
			prescale_select <= s[2:0];
			wr16(gtpwm_pkg::SEL_COUNT_HI, 16'h0000);
			run(512, 0, k);
			rd(1'b1, dh);
			rd(1'b0, dl);
			chk("base count", 16'(512 >> s), {dh, dl});
		end
		// Low byte read back is the one caught at the high-byte read
		prescale_select <= 3'h0;
		wr16(gtpwm_pkg::SEL_COUNT_HI, 16'h1234);
		rd(1'b1, dh);
		run(5, 0, k);
		rd(1'b0, dl);
		chk("coherent read", 16'h1234, {dh, dl});
		// Zero compare, compare equal to period, then random shapes
		for (int i = 0; i < 4; i++) begin
			seed = lfsr(seed);
			p = 4 + seed[3:0];
			c = (i == 0) ? 0 : (i == 1) ? p : 1 + seed[7:4] % (p - 1);
			pol = seed[8];
			output_polarity <= seed[8];
			wr16(gtpwm_pkg::SEL_PERIOD_HI, 16'(p));
			wr16(gtpwm_pkg::SEL_COMPARE_HI, 16'(c));
			wr16(gtpwm_pkg::SEL_COUNT_HI, 16'h0000);
			clr();
			chk("flags cleared", 16'h0000, {compare_flag, overflow_flag, timer_irq});
			run(9 * (p + 1), p + 1, k);
			chk("pwm high cycles", 16'(8 * (pol ? c + 1 : p - c)), 16'(k));
			chk("flags and irq", 16'h0007, {compare_flag, overflow_flag, timer_irq});
		end
		// A lone high byte must not reach the active period
		wr(gtpwm_pkg::SEL_PERIOD_HI, 8'h01);
		run(9 * (p + 1), p + 1, k);
		chk("half written period", 16'(8 * (pol ? c + 1 : p - c)), 16'(k));
		wr(gtpwm_pkg::SEL_PERIOD_LO, 8'(p));
		// Outside output mode the pin rests at the polarity level, no events
		output_level_mode <= 2'h0;
		clr();
		run(40, 0, k);
		chk("idle mode level", 16'(pol ? 40 : 0), 16'(k));
		chk("idle mode flags", 16'h0000, {compare_flag, overflow_flag, timer_irq});
		edge_case(1'b1, 1'b0, 1'b0, 4'h4, 0);
		edge_case(1'b1, 1'b0, 1'b0, 4'h9, 1);
		edge_case(1'b0, 1'b1, 1'b0, 4'h2, 1);
		edge_case(1'b1, 1'b1, 1'b1, 4'h9, 1);
		print_verdict();
	end
endmodule : general_timer_pwm_output_test
